// ### rtl/extint_consts.svh
`ifndef EXTINT_CONSTS_SVH
`define EXTINT_CONSTS_SVH
// register offsets on the plain register port
`define EXTINT_ADDR_W 4
`define EXTINT_OFS_CTRL_A 4'h0
`define EXTINT_OFS_CTRL_B 4'h1
`define EXTINT_OFS_BRK 4'h2
// field positions inside a channel status/control byte
`define EXTINT_BIT_MODE 0
`define EXTINT_BIT_MASK 1
`define EXTINT_BIT_ACK 2
`define EXTINT_BIT_FLAG 3
`define EXTINT_BIT_PUDIS 4
// field position inside the break control byte
`define EXTINT_BIT_BREAK_CLEAR_ENABLE 0
// reset values
`define EXTINT_RST_CTRL 1'b0
`define EXTINT_RST_PIN 1'b1
// edges after reset before the edge detector trusts its samples
`define EXTINT_SYNC_WARM 2'h3
`define EXTINT_RST_WARM 2'h0
`endif

// ### rtl/extint_pkg.sv
package extint_pkg;
  // per-channel request latch state
  typedef enum logic [1:0] {
    EXTINT_IDLE,
    EXTINT_PEND,
    EXTINT_ACKD
  } extint_state_t;
  // register data width
  typedef logic [7:0] extint_data_t;
endpackage : extint_pkg

// ### rtl/extint_chan.sv
`include "extint_consts.svh"
// one external interrupt channel: synchroniser, edge detect, request latch
module extint_chan
  import extint_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin, active low, asynchronous
  input wire logic pin_n,
  // controls
  input wire logic sense_level,
  input wire logic ack,
  // state
  output logic pending,
  output logic pin_level
);
  import extint_pkg::*;
  logic sync1_q, sync1_d; // first stage, read only by sync2
  logic sync2_q, sync2_d; // synchronised pin level
  logic prev_q, prev_d; // last level for edge detect
  extint_state_t st_q, st_d; // request latch
  logic fall; // falling edge seen this cycle
  logic [1:0] warm_q, warm_d; // edges since reset, saturating

  // next values of synchroniser and latch
  always_comb begin
    sync1_d = pin_n;
    sync2_d = sync1_q; // R21
    prev_d = sync2_q;
    // a pin held low through reset must not look like a fresh edge;
    // limitation: a real edge in the first cycles after reset is missed
    warm_d = (warm_q == `EXTINT_SYNC_WARM) ? warm_q : warm_q + 2'h1;
    fall = prev_q & ~sync2_q & (warm_q == `EXTINT_SYNC_WARM); // R01 R04
    st_d = st_q;
    case (st_q)
      EXTINT_IDLE: begin
        if (fall) begin
          st_d = EXTINT_PEND; // R01
        end
      end
      EXTINT_PEND: begin
        if (ack && !fall) begin
          // edge-only clears at once; level waits for high pin
          if (!sense_level || sync2_q) begin
            st_d = EXTINT_IDLE; // R05 R06
          end else begin
            st_d = EXTINT_ACKD; // R07
          end
        end
      end
      EXTINT_ACKD: begin
        if (fall) begin
          st_d = EXTINT_PEND; // R10
        end else if (!sense_level || sync2_q) begin
          st_d = EXTINT_IDLE; // R06
        end
      end
      default: begin
        st_d = EXTINT_IDLE;
      end
    endcase
  end

  // registers; a new edge beside an ack keeps the request (set wins)
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= `EXTINT_RST_PIN;
      sync2_q <= `EXTINT_RST_PIN;
      prev_q <= `EXTINT_RST_PIN;
      warm_q <= `EXTINT_RST_WARM; // R04
      st_q <= EXTINT_IDLE; // R04
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
      warm_q <= warm_d;
      st_q <= st_d;
    end
  end

  // request stays active while waiting for the pin to rise
  assign pending = (st_q != EXTINT_IDLE); // R07
  assign pin_level = sync2_q;

  property p_edge_latch;
    @(posedge clk) disable iff (!rst_n)
      (prev_q && !sync2_q && warm_q == `EXTINT_SYNC_WARM) |=> pending;
  endproperty
  a_edge_latch: assert property (p_edge_latch) else $error("edge did not latch request"); // R01

  property p_edge_clear;
    @(posedge clk) disable iff (!rst_n)
      (st_q == EXTINT_PEND && ack && !sense_level && !fall) |=> !pending;
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("edge mode ack did not clear"); // R05

  property p_level_hold;
    @(posedge clk) disable iff (!rst_n)
      (pending && sense_level && !sync2_q) |=> pending;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level request dropped while pin low"); // R07

  property p_level_release;
    @(posedge clk) disable iff (!rst_n)
      (st_q == EXTINT_ACKD && sync2_q && !fall) |=> !pending;
  endproperty
  a_level_release: assert property (p_level_release) else $error("request kept after ack and high pin"); // R06

  property p_no_ack_hold;
    @(posedge clk) disable iff (!rst_n)
      (st_q == EXTINT_PEND && !ack) |=> pending;
  endproperty
  a_no_ack_hold: assert property (p_no_ack_hold) else $error("request lost without ack"); // R02
endmodule : extint_chan

// ### rtl/extint_top.sv
// Contract
// R01 - falling edge on pin sets channel latch
// R02 - vector fetch clears only its channel
// R03 - writing ack one clears channel latch
// R04 - reset clears latches and sensitivity bits
// R05 - edge mode: acknowledge clears immediately
// R06 - level mode: needs ack and high pin
// R07 - level mode: pending while pin low
// R08 - mask withholds request, latch keeps state
// R09 - pending flag ignores mask
// R10 - ack keeps edge detection; new edge latches
// R11 - software acks before leaving service routine
// R12 - software masks level channel in routine
// R13 - channel a level goes to branch instructions
// R14 - pullup a fixed, pullup b switchable
// R15 - break clear enable lets acks work
// R16 - break clear disabled blocks break acks
// R17 - channel b pin always feeds logic
// R18 - ack reads zero; mask resets cleared
// R19 - pullup disable set turns pullup off
// R20 - sensitivity one means edge plus level
// R21 - two stage synchroniser on each pin
//
// Chosen here: the register offsets and the strobed register port.
`include "extint_consts.svh"
module extint_top
  import extint_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // external pins, active low
  input wire logic ext_int_a_pin_n,
  input wire logic ext_int_b_pin_n,
  // cpu side
  input wire logic vec_fetch_a,
  input wire logic vec_fetch_b,
  input wire logic break_state,
  output logic irq_req_a,
  output logic irq_req_b,
  output logic branch_pin_level,
  // pad control
  output logic pullup_en_a,
  output logic pullup_en_b,
  // register port
  input wire logic [`EXTINT_ADDR_W-1:0] reg_addr,
  input wire extint_pkg::extint_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output extint_pkg::extint_data_t reg_rdata
);
  import extint_pkg::*;

  logic mode_a_q, mode_a_d; // sense_select_a
  logic mode_b_q, mode_b_d; // channel b sensitivity
  logic mask_a_q, mask_a_d; // chan_mask_bit a
  logic mask_b_q, mask_b_d; // chan_mask_bit b
  logic pudis_b_q, pudis_b_d; // pullup_disable_b
  logic break_clear_enable_q, break_clear_enable_d; // break_clear_enable
  extint_data_t rdata_q, rdata_d; // read data, one cycle late
  logic wr_a, wr_b, wr_brk; // decoded writes
  logic sw_ack_a, sw_ack_b; // software acks after break gate
  logic ack_a, ack_b; // combined acks per channel
  logic pending_flag_a, pending_flag_b; // latch states
  logic lvl_a, lvl_b; // synchronised pin levels

  // address decode
  always_comb begin
    wr_a = reg_wr && (reg_addr == `EXTINT_OFS_CTRL_A);
    wr_b = reg_wr && (reg_addr == `EXTINT_OFS_CTRL_B);
    wr_brk = reg_wr && (reg_addr == `EXTINT_OFS_BRK);
  end

  // software acks; during break they only act with the enable set
  always_comb begin
    sw_ack_a = wr_a && reg_wdata[`EXTINT_BIT_ACK] && (!break_state || break_clear_enable_q); // R03 R15 R16
    sw_ack_b = wr_b && reg_wdata[`EXTINT_BIT_ACK] && (!break_state || break_clear_enable_q); // R03 R15 R16
    ack_a = sw_ack_a || vec_fetch_a; // R02
    ack_b = sw_ack_b || vec_fetch_b; // R02
  end

  // control register next values
  always_comb begin
    mode_a_d = mode_a_q;
    mask_a_d = mask_a_q;
    mode_b_d = mode_b_q;
    mask_b_d = mask_b_q;
    pudis_b_d = pudis_b_q;
    break_clear_enable_d = break_clear_enable_q;
    if (wr_a) begin
      mode_a_d = reg_wdata[`EXTINT_BIT_MODE]; // R20
      mask_a_d = reg_wdata[`EXTINT_BIT_MASK];
    end
    if (wr_b) begin
      mode_b_d = reg_wdata[`EXTINT_BIT_MODE]; // R20
      mask_b_d = reg_wdata[`EXTINT_BIT_MASK];
      pudis_b_d = reg_wdata[`EXTINT_BIT_PUDIS]; // R19
    end
    if (wr_brk) begin
      break_clear_enable_d = reg_wdata[`EXTINT_BIT_BREAK_CLEAR_ENABLE];
    end
  end

  // read mux; ack bit is never driven so it reads zero
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      case (reg_addr)
        `EXTINT_OFS_CTRL_A: begin
          rdata_d[`EXTINT_BIT_MODE] = mode_a_q;
          rdata_d[`EXTINT_BIT_MASK] = mask_a_q;
          rdata_d[`EXTINT_BIT_FLAG] = pending_flag_a; // R09
        end
        `EXTINT_OFS_CTRL_B: begin
          rdata_d[`EXTINT_BIT_MODE] = mode_b_q;
          rdata_d[`EXTINT_BIT_MASK] = mask_b_q;
          rdata_d[`EXTINT_BIT_FLAG] = pending_flag_b; // R09
          rdata_d[`EXTINT_BIT_PUDIS] = pudis_b_q;
        end
        `EXTINT_OFS_BRK: begin
          rdata_d[`EXTINT_BIT_BREAK_CLEAR_ENABLE] = break_clear_enable_q;
        end
        default: begin
          rdata_d = '0; // unmapped reads zero
        end
      endcase
    end
  end

  // register all control state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_a_q <= `EXTINT_RST_CTRL; // R04
      mode_b_q <= `EXTINT_RST_CTRL; // R04
      mask_a_q <= `EXTINT_RST_CTRL; // R18
      mask_b_q <= `EXTINT_RST_CTRL; // R18
      pudis_b_q <= `EXTINT_RST_CTRL; // R19
      break_clear_enable_q <= `EXTINT_RST_CTRL; // R16
      rdata_q <= '0;
    end else begin
      mode_a_q <= mode_a_d;
      mode_b_q <= mode_b_d;
      mask_a_q <= mask_a_d;
      mask_b_q <= mask_b_d;
      pudis_b_q <= pudis_b_d;
      break_clear_enable_q <= break_clear_enable_d;
      rdata_q <= rdata_d;
    end
  end

  // channel a: dedicated pin
  extint_chan u_chan_a (
    .clk(clk),
    .rst_n(rst_n),
    .pin_n(ext_int_a_pin_n),
    .sense_level(mode_a_q),
    .ack(ack_a),
    .pending(pending_flag_a),
    .pin_level(lvl_a)
  );

  // channel b: shared port pin, wired in regardless of port setup
  extint_chan u_chan_b (
    .clk(clk),
    .rst_n(rst_n),
    .pin_n(ext_int_b_pin_n), // R17
    .sense_level(mode_b_q),
    .ack(ack_b),
    .pending(pending_flag_b),
    .pin_level(lvl_b)
  );

  // masked requests to the priority logic; latch itself untouched
  assign irq_req_a = pending_flag_a && !mask_a_q; // R08
  assign irq_req_b = pending_flag_b && !mask_b_q; // R08
  // only channel a is visible to branch-on-level; lvl_b is for debug only
  assign branch_pin_level = lvl_a; // R13
  assign pullup_en_a = 1'b1; // R14
  assign pullup_en_b = !pudis_b_q; // R14 R19
  assign reg_rdata = rdata_q;

  property p_mask;
    @(posedge clk) disable iff (!rst_n)
      mask_a_q |-> !irq_req_a;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request reached cpu"); // R08

  property p_sw_ack;
    @(posedge clk) disable iff (!rst_n)
      (sw_ack_b && !mode_b_q && !break_state && pending_flag_b && lvl_b && $past(lvl_b)) |=> !pending_flag_b;
  endproperty
  a_sw_ack: assert property (p_sw_ack) else $error("software ack did not clear"); // R03

  property p_break_block;
    @(posedge clk) disable iff (!rst_n)
      (wr_a && reg_wdata[`EXTINT_BIT_ACK] && break_state && !break_clear_enable_q && pending_flag_a && !vec_fetch_a
        && !mode_a_q && !$past(mode_a_q))
        |=> pending_flag_a;
  endproperty
  a_break_block: assert property (p_break_block) else $error("ack acted in break"); // R16

  property p_ack_reads_zero;
    @(posedge clk) disable iff (!rst_n)
      reg_rd |=> !reg_rdata[`EXTINT_BIT_ACK];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read as one"); // R18

  property p_pullup;
    @(posedge clk) disable iff (!rst_n)
      (wr_b && reg_wdata[`EXTINT_BIT_PUDIS]) |=> !pullup_en_b && pullup_en_a;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullup not disabled"); // R19

  property p_flag;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `EXTINT_OFS_CTRL_B) |=> reg_rdata[`EXTINT_BIT_FLAG] == $past(pending_flag_b);
  endproperty
  a_flag: assert property (p_flag) else $error("flag read wrong"); // R09

  // flag of channel a reads the latch, mask or not
  property p_flag_a;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `EXTINT_OFS_CTRL_A) |=> reg_rdata[`EXTINT_BIT_FLAG] == $past(pending_flag_a);
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("flag a read wrong"); // R09

  // channel b mask withholds its request as well
  property p_mask_b;
    @(posedge clk) disable iff (!rst_n)
      mask_b_q |-> !irq_req_b;
  endproperty
  a_mask_b: assert property (p_mask_b) else $error("masked request b reached cpu"); // R08

  // acks in break act once the enable is set; stable pin means no new edge
  property p_break_clear;
    @(posedge clk) disable iff (!rst_n)
      (wr_a && reg_wdata[`EXTINT_BIT_ACK] && break_state && break_clear_enable_q && !mode_a_q && lvl_a == $past(lvl_a))
        |=> !pending_flag_a;
  endproperty
  a_break_clear: assert property (p_break_clear) else $error("break ack with enable did not clear"); // R15

  // branch level is the pin two edges late, once both stages hold real samples
  property p_branch_level;
    @(posedge clk) disable iff (!rst_n)
      ($past(rst_n) && $past(rst_n, 2)) |-> branch_pin_level == $past(ext_int_a_pin_n, 2);
  endproperty
  a_branch_level: assert property (p_branch_level) else $error("branch level not the synced pin"); // R13

  // first edge after reset shows every reset value
  property p_reset_vals;
    @(posedge clk) disable iff (!rst_n)
      !$past(rst_n) |-> (!irq_req_a && !irq_req_b && !mode_a_q && !mode_b_q && !mask_a_q && !mask_b_q
        && !break_clear_enable_q && pullup_en_b && branch_pin_level && reg_rdata == '0);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("state not cleared by reset"); // R04

  // clearing the disable bit turns the pullup back on
  property p_pullup_on;
    @(posedge clk) disable iff (!rst_n)
      (wr_b && !reg_wdata[`EXTINT_BIT_PUDIS]) |=> pullup_en_b;
  endproperty
  a_pullup_on: assert property (p_pullup_on) else $error("pullup not enabled"); // R19

  // sensitivity of channel a follows its write
  property p_mode_a_write;
    @(posedge clk) disable iff (!rst_n)
      wr_a |=> mode_a_q == $past(reg_wdata[`EXTINT_BIT_MODE]);
  endproperty
  a_mode_a_write: assert property (p_mode_a_write) else $error("mode a not written"); // R20

  // sensitivity of channel b follows its write
  property p_mode_b_write;
    @(posedge clk) disable iff (!rst_n)
      wr_b |=> mode_b_q == $past(reg_wdata[`EXTINT_BIT_MODE]);
  endproperty
  a_mode_b_write: assert property (p_mode_b_write) else $error("mode b not written"); // R20

  // mask of channel a is read/write
  property p_mask_a_write;
    @(posedge clk) disable iff (!rst_n)
      wr_a |=> mask_a_q == $past(reg_wdata[`EXTINT_BIT_MASK]);
  endproperty
  a_mask_a_write: assert property (p_mask_a_write) else $error("mask a not written"); // R18

  // mask of channel b is read/write
  property p_mask_b_write;
    @(posedge clk) disable iff (!rst_n)
      wr_b |=> mask_b_q == $past(reg_wdata[`EXTINT_BIT_MASK]);
  endproperty
  a_mask_b_write: assert property (p_mask_b_write) else $error("mask b not written"); // R18

  // break clear enable follows its write
  property p_break_clear_enable_write;
    @(posedge clk) disable iff (!rst_n)
      wr_brk |=> break_clear_enable_q == $past(reg_wdata[`EXTINT_BIT_BREAK_CLEAR_ENABLE]);
  endproperty
  a_break_clear_enable_write: assert property (p_break_clear_enable_write) else $error("break enable not written"); // R15

  // read data only stands in the cycle after a read strobe
  property p_rdata_idle;
    @(posedge clk) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle"); // R18
endmodule : extint_top

// ### testbench/extint_cpu_model.sv
// cpu side stand-in: answers an unmasked request with a vector fetch pulse
module extint_cpu_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // requests in, fetches out
  input wire logic irq_req_a,
  input wire logic irq_req_b,
  output logic vec_fetch_a,
  output logic vec_fetch_b,
  // bench control: enable and holdoff after a fetch
  input wire logic en,
  input wire logic [3:0] dly
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q; // holdoff so one request is fetched once
  // channel a wins when both are asking, like a priority encoder
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_fetch_a <= 1'b0;
      vec_fetch_b <= 1'b0;
      wait_q <= 4'h0;
    end else begin
      vec_fetch_a <= 1'b0;
      vec_fetch_b <= 1'b0;
      if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (en && irq_req_a) begin
        vec_fetch_a <= 1'b1;
        wait_q <= dly;
      end else if (en && irq_req_b) begin
        vec_fetch_b <= 1'b1;
        wait_q <= dly;
      end
    end
  end
endmodule : extint_cpu_model

// ### testbench/tb_top.sv
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top import extint_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // stimulus and observed signals
  logic clk = 0, rst_n = 0, pin_a_n = 1, pin_b_n = 1, brk = 0, wr = 0, rd = 0, rd_d = 0, en = 0;
  logic vfa, vfb, ira, irb, bpl, pua, pub;
  logic [3:0] addr = 4'h0, dly = 4'h2;
  extint_data_t wd = 8'h00, rdat, e_v;
  extint_data_t exp_q[$]; // expected read data, oldest first
  int err_count = 0, checks = 0, seed = 32'h16186bee;
  always #50 clk = ~clk;
  extint_top dut (.clk(clk), .rst_n(rst_n), .ext_int_a_pin_n(pin_a_n), .ext_int_b_pin_n(pin_b_n),
    .vec_fetch_a(vfa), .vec_fetch_b(vfb), .break_state(brk), .irq_req_a(ira), .irq_req_b(irb),
    .branch_pin_level(bpl), .pullup_en_a(pua), .pullup_en_b(pub), .reg_addr(addr),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat));
  extint_cpu_model cpu (.clk(clk), .rst_n(rst_n), .irq_req_a(ira), .irq_req_b(irb),
    .vec_fetch_a(vfa), .vec_fetch_b(vfb), .en(en), .dly(dly));
  // read data stands only in the cycle after the strobe
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) begin
      e_v = exp_q.pop_front();
      `CHK("reg_rdata", e_v, rdat)
    end
  end
  task wr_reg(input logic [3:0] a, input extint_data_t d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, input extint_data_t e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  // random settle time covers synchroniser plus edge detect
  task pins(input logic a, input logic b);
    @(posedge clk);
    pin_a_n <= a;
    pin_b_n <= b;
    repeat (6 + ($random(seed) & 3)) @(posedge clk);
    @(negedge clk);
  endtask : pins
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(4'h0, 8'h00);
    rd_reg(4'h1, 8'h00);
    rd_reg(4'h2, 8'h00);
    wr_reg(4'h9, extint_data_t'($random(seed)));
    rd_reg(4'h9, 8'h00);
    `CHK("pullup_en_a", 1'b1, pua)
    `CHK("pullup_en_b", 1'b1, pub)
    $display("test reset done");
    pins(0, 1);
    `CHK("irq_req_a", 1'b1, ira)
    `CHK("irq_req_b", 1'b0, irb)
    `CHK("branch_pin_level", 1'b0, bpl)
    rd_reg(4'h0, 8'h08);
    wr_reg(4'h0, 8'h04);
    rd_reg(4'h0, 8'h00);
    pins(1, 1);
    pins(0, 1);
    rd_reg(4'h0, 8'h08);
    wr_reg(4'h0, 8'h04);
    pins(1, 1);
    `CHK("branch_pin_level", 1'b1, bpl)
    $display("test edge done");
    wr_reg(4'h0, 8'h01);
    pins(0, 1);
    wr_reg(4'h0, 8'h05);
    rd_reg(4'h0, 8'h09);
    pins(1, 1);
    rd_reg(4'h0, 8'h01);
    pins(0, 1);
    pins(1, 1);
    rd_reg(4'h0, 8'h09);
    wr_reg(4'h0, 8'h04);
    rd_reg(4'h0, 8'h00);
    $display("test level done");
    wr_reg(4'h0, 8'h02);
    wr_reg(4'h1, 8'h02);
    pins(0, 0);
    `CHK("irq_req_a", 1'b0, ira)
    rd_reg(4'h1, 8'h0a);
    en <= 1'b1;
    wr_reg(4'h1, 8'h00);
    repeat (8) @(posedge clk);
    rd_reg(4'h1, 8'h00);
    rd_reg(4'h0, 8'h0a);
    dly <= 4'h6;
    wr_reg(4'h0, 8'h00);
    repeat (12) @(posedge clk);
    rd_reg(4'h0, 8'h00);
    en <= 1'b0;
    pins(1, 1);
    $display("test fetch done");
    @(posedge clk);
    brk <= 1'b1;
    pins(0, 1);
    wr_reg(4'h0, 8'h04);
    rd_reg(4'h0, 8'h08);
    wr_reg(4'h2, 8'h01);
    wr_reg(4'h0, 8'h04);
    rd_reg(4'h2, 8'h01);
    brk <= 1'b0;
    rd_reg(4'h0, 8'h00);
    wr_reg(4'h2, 8'h00);
    pins(1, 1);
    $display("test break done");
    wr_reg(4'h1, 8'h01);
    pins(1, 0);
    `CHK("irq_req_b", 1'b1, irb)
    `CHK("irq_req_a", 1'b0, ira)
    wr_reg(4'h1, 8'h05);
    rd_reg(4'h1, 8'h09);
    pins(1, 1);
    rd_reg(4'h1, 8'h01);
    wr_reg(4'h1, 8'h00);
    pins(1, 0);
    pins(1, 1);
    wr_reg(4'h1, 8'h04);
    rd_reg(4'h1, 8'h00);
    $display("test chan b done");
    wr_reg(4'h1, 8'h10);
    rd_reg(4'h1, 8'h10);
    @(negedge clk);
    `CHK("pullup_en_b", 1'b0, pub)
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h0, 8'h01);
    pins(0, 1);
    rst_n = 1'b0;
    @(negedge clk);
    `CHK("irq_req_a", 1'b0, ira)
    @(posedge clk);
    rst_n <= 1'b1;
    pins(1, 1);
    rd_reg(4'h0, 8'h00);
    wr_reg(4'h0, 8'h04);
    rd_reg(4'h0, 8'h00);
    repeat (2) @(posedge clk);
    $display("test misc done");
    wrap_up();
  end
endmodule : tb_top
